// ### hw/dsq_strobe_seq.sv
/*
 Strobe sequencer of a dynamic RAM controller: row strobe, column strobe,
 row/column address multiplexing, hidden refresh and access-grant cycles.
 Assumes host strobes and addresses arrive asynchronously and are held
 for several controller clocks; the refresh timer lives elsewhere.
*/
// How it works
// RULE_01 - Latch strobe fall captures inputs, lowers row strobe
// RULE_02 - Access fall switches address, then column strobe
// RULE_03 - Column timed from latch or access fall
// RULE_04 - Latch rise raises row strobe, passes row
// RULE_05 - Access rise raises column strobe
// RULE_06 - Access rise ends row, column, address
// RULE_07 - Host measures precharge from access rise
// RULE_08 - Early access: latch fall controls everything
// RULE_09 - Row address held 30 ns minimum; an early-access grant switches to column one 20 ns clock after the row strobe
// RULE_10 - Host may tie both strobes together
// RULE_11 - Late access rise: latch raises row
// RULE_12 - Host holds access low for hidden refresh
// RULE_13 - Grant refresh when request pending, latch high
// RULE_14 - Refresh row strobe one or two cycles
// RULE_15 - Latch fall in refresh drops ready
// RULE_16 - Refresh end raises ready, lowers row
// RULE_17 - Grant column timing by access strobe lateness
// RULE_18 - Wait-state option adds one ready cycle
// RULE_19 - Host times latch rise for precharge
// RULE_20 - Read or write strobe acts alike
`timescale 1ns/1ns
module dsq_strobe_seq import dsq_pkg::*; (
   input wire logic clk_sys, // controller clock
   input wire logic sys_rst, // async reset, high
   input wire logic ale, // address-latch strobe, high
   input wire logic read_access_strobe_n, // read access strobe
   input wire logic write_access_strobe_n, // write access strobe
   input wire logic chip_select_n, // chip select
   input wire logic row_bank_select, // 0 bank 0, 1 bank 1
   input wire logic [7:0] row_addr_in, // row address
   input wire logic [7:0] col_addr_in, // column address
   input wire logic refresh_request_n, // refresh request, low
   input wire logic wait_state_select, // one grant wait state
   input wire logic refresh_four_cycle, // 1: four-cycle refresh
   output logic [1:0] row_strobe_n, // row strobes per bank
   output logic col_strobe_n, // column strobe
   output logic [7:0] mem_addr_out, // multiplexed DRAM address
   output logic ready_out, // processor ready
   output logic refresh_busy // refresh cycle running
);
   logic [SYNC_W-1:0] raw_vec;
   logic [SYNC_W-1:0] syn_vec;
   logic ale_s;
   logic acc_low;
   logic cs_n_s;
   logic bank_s;
   logic ref_n_s;
   logic wst_s;
   logic four_s;
   logic [7:0] row_s;
   logic [7:0] col_s;
   logic ale_fall;
   logic ale_rise;
   logic acc_rise;
   logic in_ref;
   logic [1:0] ref_len;
   logic [1:0] bank_ras;
   dsq_regs_t q;
   dsq_regs_t d;

   assign raw_vec = {ale, read_access_strobe_n, write_access_strobe_n, chip_select_n,
      row_bank_select, refresh_request_n, wait_state_select, refresh_four_cycle,
      row_addr_in, col_addr_in};

   // Pins are asynchronous to the controller clock
   dsq_sync #(.W(SYNC_W), .RST_VAL(SYNC_RST)) u_sync (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .din(raw_vec),
      .dout(syn_vec)
   );

   assign ale_s = syn_vec[23];
   assign acc_low = ~(syn_vec[22] & syn_vec[21]); // [RULE_20]
   assign cs_n_s = syn_vec[20];
   assign bank_s = syn_vec[19];
   assign ref_n_s = syn_vec[18];
   assign wst_s = syn_vec[17];
   assign four_s = syn_vec[16];
   assign row_s = syn_vec[15:8];
   assign col_s = syn_vec[7:0];

   assign ale_fall = q.ale_p & ~ale_s;
   assign ale_rise = ~q.ale_p & ale_s;
   assign acc_rise = q.acc_p & ~acc_low;
   assign in_ref = (q.st == DSQ_RPRE) || (q.st == DSQ_REF);
   assign ref_len = four_s ? REF_LOW_CYC_4 : REF_LOW_CYC_3;
   assign bank_ras = q.bank ? 2'h1 : 2'h2;

   always_comb begin
      d = q;
      d.ale_p = ale_s;
      d.acc_p = acc_low;

      // Ending the column strobe needs no state: any access rise does it
      if (acc_rise) begin
         d.cas_n = 1'b1; // [RULE_05]
      end

      // Row latches are transparent while the latch strobe is high, the row strobe is idle and no refresh runs
      if (ale_s && !in_ref && q.ras_n == RAS_IDLE) begin
         d.ma = row_s; // [RULE_04]
      end

      case (q.st)
         DSQ_IDLE: begin
            if (ale_fall) begin
               d.cs_n = cs_n_s; // [RULE_01]
               d.bank = bank_s;
               d.row = row_s;
               d.col = col_s;
               d.ma = row_s;
               d.cnt = 2'h0;
               if (!cs_n_s) begin
                  d.ras_n = bank_s ? 2'h1 : 2'h2; // [RULE_01]
                  d.st = DSQ_ROW;
               end
            end else if (q.ref_pend && ale_s) begin
               d.ma = q.ref_addr; // [RULE_13]
               d.st = DSQ_RPRE;
            end
         end
         DSQ_ROW: begin
            if (q.cnt != 2'h3) begin
               d.cnt = q.cnt + 2'h1;
            end
            if (!q.rdy) begin
               d.rdy = 1'b1; // [RULE_18]
            end
            if (acc_rise || ale_rise) begin
               d.ras_n = RAS_IDLE;
               d.ma = row_s;
               d.st = DSQ_IDLE;
            end else if (acc_low && q.cnt >= ROW_HOLD_CYC) begin
               // Counting from the row strobe covers both the early and late case
               d.ma = q.col; // [RULE_02] [RULE_03] [RULE_08] [RULE_09]
               d.st = DSQ_COL;
            end
         end
         DSQ_COL: begin
            if (acc_rise) begin
               d.ras_n = RAS_IDLE;
               d.ma = row_s;
               d.st = DSQ_IDLE;
            end else begin
               d.cas_n = 1'b0; // [RULE_02]
               d.st = DSQ_ACT;
            end
         end
         DSQ_ACT: begin
            if (ale_rise && acc_low) begin
               d.ras_n = RAS_IDLE; // [RULE_04] [RULE_11]
               d.ma = row_s;
            end
            if (acc_rise) begin
               d.ras_n = RAS_IDLE; // [RULE_06]
               d.ma = row_s;
               d.st = DSQ_IDLE;
            end else if (q.ras_n == RAS_IDLE && q.ref_pend && ale_s) begin
               // Column strobe stays low so DRAM data stays valid [RULE_12]
               d.ma = q.ref_addr; // [RULE_13]
               d.st = DSQ_RPRE;
            end
         end
         DSQ_RPRE: begin
            d.ras_n = 2'h0; // [RULE_14]
            d.cnt = 2'h0;
            d.st = DSQ_REF;
         end
         DSQ_REF: begin
            d.cnt = q.cnt + 2'h1;
            if (q.cnt == ref_len - 2'h1) begin
               d.ras_n = RAS_IDLE; // [RULE_14]
               d.ref_addr = q.ref_addr + 8'h01;
               d.ref_pend = 1'b0;
               if (q.grant || ale_fall) begin
                  d.grant_go = 1'b1;
               end else if (!q.cas_n) begin
                  d.st = DSQ_ACT;
               end else begin
                  d.st = DSQ_IDLE;
               end
            end
         end
         default: begin
            d.st = DSQ_IDLE;
            d.ras_n = RAS_IDLE;
            d.cas_n = 1'b1;
         end
      endcase

      // Latch strobe falling into a refresh with chip select low starts an access grant
      if (ale_fall && in_ref) begin
         d.cs_n = cs_n_s;
         d.bank = bank_s;
         d.row = row_s;
         d.col = col_s;
         d.grant = ~cs_n_s;
         d.rdy = cs_n_s; // [RULE_15]
         d.acc_early = acc_low; // [RULE_17]
         if (q.st == DSQ_REF && q.cnt == ref_len - 2'h1) begin
            d.grant_go = ~cs_n_s;
         end
      end

      // Clock edge after refresh: grant row strobe and release ready unless the wait state is selected
      if (q.grant_go) begin
         d.grant_go = 1'b0;
         d.grant = 1'b0;
         d.ras_n = bank_ras; // [RULE_16]
         d.ma = q.row;
         d.rdy = ~wst_s; // [RULE_16] [RULE_18]
         // Early strobe skips the extra cycle: column one clock period sooner
         d.cnt = q.acc_early ? ROW_HOLD_CYC : ROW_HOLD_CYC - 2'h1; // [RULE_17]
         d.st = DSQ_ROW;
      end

      // A request seen while the pending flag clears keeps it set
      if (!ref_n_s) begin
         d.ref_pend = 1'b1; // [RULE_13]
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         q <= '{st: DSQ_IDLE, ale_p: 1'b0, acc_p: 1'b0, cs_n: 1'b1, bank: 1'b0,
            row: ADDR_RST, col: ADDR_RST, cnt: 2'h0, ras_n: RAS_IDLE, cas_n: 1'b1,
            ma: ADDR_RST, rdy: 1'b1, ref_addr: ADDR_RST, ref_pend: 1'b0,
            grant: 1'b0, grant_go: 1'b0, acc_early: 1'b0};
         refresh_busy <= 1'b0;
      end else begin
         q <= d;
         refresh_busy <= (d.st == DSQ_RPRE) || (d.st == DSQ_REF);
      end
   end

   assign row_strobe_n = q.ras_n;
   assign col_strobe_n = q.cas_n;
   assign mem_addr_out = q.ma;
   assign ready_out = q.rdy;
endmodule

// ### hw/dsq_pkg.sv
/*
 Package for the dynamic RAM strobe sequencer: states, state record,
 timing counts and reset values.
 Assumes a single controller clock at the rate named below.
*/
package dsq_pkg;

   // Controller clock
   localparam int CLK_PERIOD_NS = 20;

   // Row address hold after row strobe falls, least time, rounded up
   localparam int ROW_HOLD_NS = 30;
   localparam int ROW_HOLD_CYC_I = (ROW_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [1:0] ROW_HOLD_CYC = ROW_HOLD_CYC_I[1:0];

   // Access-grant strobe windows; at this clock both resolve to one sample
   localparam int GRANT_LATE_NS = 20;
   localparam int GRANT_EARLY_NS = 2;

   // Refresh row strobe low time in clock cycles
   localparam logic [1:0] REF_LOW_CYC_3 = 2'h1;
   localparam logic [1:0] REF_LOW_CYC_4 = 2'h2;

   // Synchroniser vector: ale, rd_n, wr_n, cs_n, bank, ref_n, wst, four, row, col
   localparam int SYNC_W = 24;
   localparam logic [SYNC_W-1:0] SYNC_RST = 24'h770000;

   localparam logic [7:0] ADDR_RST = 8'h00;
   localparam logic [1:0] RAS_IDLE = 2'h3;

   typedef enum logic [5:0] {
      DSQ_IDLE = 6'h01,
      DSQ_ROW  = 6'h02,
      DSQ_COL  = 6'h04,
      DSQ_ACT  = 6'h08,
      DSQ_RPRE = 6'h10,
      DSQ_REF  = 6'h20
   } dsq_state_t;

   typedef struct packed {
      dsq_state_t st;
      logic ale_p;
      logic acc_p;
      logic cs_n;
      logic bank;
      logic [7:0] row;
      logic [7:0] col;
      logic [1:0] cnt;
      logic [1:0] ras_n;
      logic cas_n;
      logic [7:0] ma;
      logic rdy;
      logic [7:0] ref_addr;
      logic ref_pend;
      logic grant;
      logic grant_go;
      logic acc_early;
   } dsq_regs_t;

endpackage

// ### hw/dsq_sync.sv
/*
 Two-stage synchroniser for a vector of unrelated level inputs.
 Assumes each bit is a level held for several clocks; no bus coherence.
*/
`timescale 1ns/1ns
module dsq_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk_sys, // controller clock
   input wire logic sys_rst, // async reset, high
   input wire logic [W-1:0] din, // asynchronous levels
   output logic [W-1:0] dout // synchronised levels
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         meta_q <= RST_VAL;
         dout <= RST_VAL;
      end else begin
         meta_q <= din;
         dout <= meta_q;
      end
   end
endmodule

// ### testbench/dsq_strobe_seq_checker.sv
/* Output checker for the strobe sequencer.
 Assumes bind to dsq_strobe_seq; host holds option pins steady. */
`timescale 1ns/1ns
module dsq_strobe_seq_checker (
   input wire logic clk_sys, // clock
   input wire logic sys_rst, // reset
   input wire logic wait_state_select, // wait option
   input wire logic refresh_four_cycle, // refresh length
   input wire logic [1:0] row_strobe_n, // row strobes
   input wire logic col_strobe_n, // column strobe
   input wire logic [7:0] mem_addr_out, // address
   input wire logic ready_out, // ready
   input wire logic refresh_busy // refresh running
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   // Grant cycles excluded: their column switch is clock timed
   a_row_hold: assert property (row_strobe_n inside {2'h1, 2'h2} && $past(row_strobe_n) == 2'h3
      && $past(ready_out) |=> $stable(mem_addr_out)) else $error("row address not held");
   a_cas_addr: assert property ($fell(col_strobe_n) |-> $stable(mem_addr_out)
      && row_strobe_n inside {2'h1, 2'h2}) else $error("column strobe before address");
   a_cas_rise_ras: assert property ($rose(col_strobe_n) |-> row_strobe_n == 2'h3)
      else $error("row strobe low after column rise");
   a_both_low: assert property (row_strobe_n == 2'h0 |-> refresh_busy)
      else $error("both banks low outside refresh");
   a_ref_three: assert property ($past(row_strobe_n) == 2'h3 && row_strobe_n == 2'h0
      && !refresh_four_cycle |=> row_strobe_n == 2'h3) else $error("short refresh width");
   a_ref_four: assert property ($past(row_strobe_n) == 2'h3 && row_strobe_n == 2'h0
      && refresh_four_cycle |=> row_strobe_n == 2'h0 ##1 row_strobe_n == 2'h3)
      else $error("long refresh width");
   a_grant_ras: assert property ($rose(ready_out) |->
      (wait_state_select ? $past(row_strobe_n) : row_strobe_n) inside {2'h1, 2'h2})
      else $error("grant row strobe misplaced");
   a_ready_len: assert property ($fell(ready_out) |-> ##[1:12] ready_out)
      else $error("ready held low too long");
   a_busy_len: assert property ($rose(refresh_busy) |-> ##[1:4] !refresh_busy)
      else $error("refresh too long");
   c_grant: cover property ($rose(ready_out));
   c_col: cover property ($fell(col_strobe_n));
   c_ref: cover property (row_strobe_n == 2'h0);
endmodule

// ### testbench/dsq_dram_model.sv
/* DRAM array model: latches row and column on strobe falls, counts refreshes.
 Assumes registered strobes; samples on the falling clock, when settled. */
`timescale 1ns/1ns
module dsq_dram_model (
   input wire logic clk_sys, // clock
   input wire logic [1:0] row_strobe_n, // row strobes
   input wire logic col_strobe_n, // column strobe
   input wire logic [7:0] mem_addr_out, // address
   output logic [7:0] row_q, // last row
   output logic [7:0] col_q, // last column
   output logic [7:0] ref_q // refreshes seen
);
   logic [1:0] ras_q;
   logic cas_q;
   initial begin
      row_q = 8'h00;
      col_q = 8'h00;
      ref_q = 8'h00;
      ras_q = 2'h3;
      cas_q = 1'b1;
   end
   always @(negedge clk_sys) begin
      if (ras_q == 2'h3 && row_strobe_n inside {2'h1, 2'h2}) row_q <= mem_addr_out;
      if (ras_q == 2'h3 && row_strobe_n == 2'h0) ref_q <= ref_q + 8'h01;
      if (cas_q && !col_strobe_n) col_q <= mem_addr_out;
      ras_q <= row_strobe_n;
      cas_q <= col_strobe_n;
   end
endmodule

// ### testbench/dsq_strobe_seq_tb_top.sv
/* Testbench for the strobe sequencer: access orders, hidden refresh, grants.
 Assumes the DRAM model and checker files are compiled first. */
`timescale 1ns/1ns
module dsq_strobe_seq_tb_top;
   logic clk_sys = 0, sys_rst = 1, ale = 0, rd_n = 1, wr_n = 1, cs_n = 0, bank = 0;
   logic rq_n = 1, wst = 0, four = 0, cas, rdy, busy;
   logic [7:0] ra = 8'h00, ca = 8'h00, ma, row_q, col_q, ref_q;
   logic [1:0] ras;
   int n_fail = 0, n_compared = 0;
   always #10 clk_sys = ~clk_sys;
   dsq_strobe_seq DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .ale(ale),
      .read_access_strobe_n(rd_n), .write_access_strobe_n(wr_n), .chip_select_n(cs_n),
      .row_bank_select(bank), .row_addr_in(ra), .col_addr_in(ca), .refresh_request_n(rq_n),
      .wait_state_select(wst), .refresh_four_cycle(four), .row_strobe_n(ras),
      .col_strobe_n(cas), .mem_addr_out(ma), .ready_out(rdy), .refresh_busy(busy));
   dsq_dram_model u_dram (.clk_sys(clk_sys), .row_strobe_n(ras), .col_strobe_n(cas),
      .mem_addr_out(ma), .row_q(row_q), .col_q(col_q), .ref_q(ref_q));
   task automatic tk(int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         $display("Error %s expected %h seen %h", nm, e, g);
         n_fail++;
      end
   endtask
   // A level that never arrives is a mismatch, not a silent pass
   task automatic wait_on(string nm, ref logic s, input logic v);
      for (int i = 0; i < 30 && s !== v; i++) begin
         tk(1);
      end
      chk(nm, {7'h00, v}, {7'h00, s});
   endtask
   task automatic start(logic b, logic [7:0] r, logic [7:0] c);
      bank = b;
      ra = r;
      ca = c;
      ale = 1'b1;
      tk(4);
   endtask
   task automatic s_lead;
      start(1'b0, 8'hA5, 8'h3C);
      ale = 1'b0;
      tk(5);
      rd_n = 1'b0;
      wait_on("cas low", cas, 1'b0);
      tk(1);
      chk("row", 8'hA5, row_q);
      chk("col", 8'h3C, col_q);
      chk("ras", 8'h02, ras);
      ra = 8'h5A;
      ale = 1'b1;
      tk(4);
      chk("ras", 8'h03, ras);
      chk("ma", 8'h5A, ma);
      chk("cas", 8'h00, cas);
      rd_n = 1'b1;
      tk(4);
      chk("cas", 8'h01, cas);
      // Precharge gap before the next latch fall
      tk(6);
   endtask
   task automatic s_over;
      start(1'b1, 8'hC3, 8'h96);
      ale = 1'b0;
      tk(4);
      wr_n = 1'b0;
      wait_on("cas low", cas, 1'b0);
      tk(1);
      chk("col", 8'h96, col_q);
      chk("ras", 8'h01, ras);
      wr_n = 1'b1;
      tk(4);
      chk("ras", 8'h03, ras);
      chk("cas", 8'h01, cas);
      chk("ma", 8'hC3, ma);
      ale = 1'b1;
      tk(6);
      chk("ras", 8'h03, ras);
   endtask
   task automatic s_early;
      cs_n = 1'b1;
      ale = 1'b0;
      tk(10);
      chk("ras", 8'h03, ras);
      cs_n = 1'b0;
      start(1'b0, 8'h0F, 8'hF0);
      rd_n = 1'b0;
      tk(3);
      ale = 1'b0;
      wait_on("cas low", cas, 1'b0);
      tk(1);
      chk("row", 8'h0F, row_q);
      chk("col", 8'hF0, col_q);
      rd_n = 1'b1;
      ale = 1'b1;
      tk(5);
      chk("ras", 8'h03, ras);
      chk("cas", 8'h01, cas);
   endtask
   task automatic s_hidden;
      logic [7:0] n0;
      n0 = ref_q;
      start(1'b1, 8'h11, 8'h22);
      ale = 1'b0;
      tk(4);
      rd_n = 1'b0;
      wait_on("cas low", cas, 1'b0);
      // One-clock request: a held level is seen again as the pending flag clears
      rq_n = 1'b0;
      ale = 1'b1;
      tk(1);
      rq_n = 1'b1;
      wait_on("busy high", busy, 1'b1);
      wait_on("busy low", busy, 1'b0);
      tk(2);
      chk("cas", 8'h00, cas);
      chk("refs", n0 + 8'h01, ref_q);
      rd_n = 1'b1;
      tk(4);
      chk("cas", 8'h01, cas);
   endtask
   task automatic s_grant;
      int c[3];
      int g[3];
      logic low;
      four = 1'b1;
      // Pass 0 early access, pass 1 adds the wait state, pass 2 lowers access late
      for (int w = 0; w < 3; w++) begin
         wst = (w == 1);
         c[w] = 0;
         g[w] = 0;
         low = 1'b0;
         bank = 1'b0;
         ra = 8'h40 + w[7:0];
         ca = 8'h80 + w[7:0];
         tk(4);
         rq_n = 1'b0;
         tk(1);
         rq_n = 1'b1;
         wait_on("busy high", busy, 1'b1);
         ale = 1'b0;
         rd_n = (w == 2);
         for (int i = 0; i < 20; i++) begin
            tk(1);
            rd_n = 1'b0;
            if (rdy === 1'b0) begin
               c[w]++;
               low = 1'b1;
            end else if (low && cas === 1'b1) begin
               g[w]++;
            end
         end
         chk("row", 8'h40 + w[7:0], row_q);
         chk("col", 8'h80 + w[7:0], col_q);
         rd_n = 1'b1;
         ale = 1'b1;
         tk(6);
      end
      chk("rdy0", 8'h01, {7'h00, c[0] > 0});
      chk("rdy1", c[0][7:0] + 8'h01, c[1][7:0]);
      chk("rdy2", c[0][7:0], c[2][7:0]);
      chk("cas late", g[0][7:0] + 8'h01, g[2][7:0]);
   endtask
   task automatic give_verdict;
      $display("Compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      tk(5); sys_rst = 0; tk(3);
      s_lead; s_over; s_early; s_hidden; s_grant;
      give_verdict;
   end
   // Whole run is well under a thousand cycles
   initial begin
      #300000;
      n_fail++;
      give_verdict;
   end
endmodule
bind dsq_strobe_seq dsq_strobe_seq_checker u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
   .wait_state_select(wait_state_select), .refresh_four_cycle(refresh_four_cycle),
   .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n), .mem_addr_out(mem_addr_out),
   .ready_out(ready_out), .refresh_busy(refresh_busy));
